// [lcd_timing_pkg.sv]
// Shared constants, reset values and carrier types of the LCD timing block.
// Assumes one core clock and a synchronous, active-high reset.
package lcd_timing_pkg;

  // ****************************************************************
  // Clock, widths and codes
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int PRESCALE_W = 7;
  localparam int PIX_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BUS_1BIT = 2'h0;
  localparam logic [1:0] BUS_2BIT = 2'h1;
  localparam logic [1:0] BUS_4BIT = 2'h2;
  localparam logic [1:0] FRAME_EDGE_SHIFTS = 2'h2;
  localparam logic [5:0] LOFS_IDLE = 6'h3F;
  localparam logic [3:0] DATA_RST = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {ST_IDLE, ST_RUN} mode_t;

  typedef struct packed {
    logic [2:0] prescale_select;
    logic [4:0] shift_period_count;
    logic [4:0] shift_high_count;
    logic [4:0] line_rise_offset;
    logic [4:0] line_fall_offset;
    logic [7:0] line_width_count;
    logic [7:0] panel_height_count;
    logic [1:0] bus_width;
  } cfg_t;

  typedef struct packed {
    mode_t mode;
    logic [4:0] sph;
    logic [10:0] idx;
    logic [8:0] row;
    logic [5:0] lofs;
    logic [8:0] frow;
    logic [1:0] fdly;
    logic shift_clock;
    logic lclk;
    logic frame;
    logic [3:0] data;
    logic underrun;
  } tim_st_t;

  localparam tim_st_t TIM_RST = '{mode: ST_IDLE, sph: 5'h00,
    idx: 11'h000, row: 9'h000, lofs: LOFS_IDLE, frow: 9'h000,
    fdly: 2'h0, shift_clock: 1'b0, lclk: 1'b0, frame: 1'b0,
    data: DATA_RST, underrun: 1'b0};

endpackage

// [lcd_prescaler.sv]
// Pixel prescale tick generator: one core-clock pulse every 2**N cycles.
// Assumes select is stable while running.
`timescale 1ns/1ps
module lcd_prescaler
  import lcd_timing_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  output logic o_tick
);

  typedef struct packed {
    logic [PRESCALE_W-1:0] cnt;
    logic tick;
  } pre_st_t;

  pre_st_t s_r;
  pre_st_t s_nxt;
  logic [PRESCALE_W:0] span;
  logic [PRESCALE_W-1:0] mask;

  assign span = (PRESCALE_W+1)'(1) << i_sel;
  assign mask = PRESCALE_W'(span - (PRESCALE_W+1)'(1));

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!i_run)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt >= mask)
    begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + PRESCALE_W'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_tick = s_r.tick;

  tick_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_run && s_r.cnt == mask) |=> (o_tick && s_r.cnt == '0))
    else $error("Prescale tick missed its 2**N slot.");

endmodule // lcd_prescaler

// [lcd_pix_fifo.sv]
// Pixel word FIFO between the pixel source and the shift-clock pacer.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps
module lcd_pix_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = i_in_valid && s_r.rdy;
  assign pop = i_out_ready && (s_r.cnt != '0);

  always_comb
  begin
    s_nxt = s_r;
    if (push)
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + AW'(1);
    if (pop)
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + AW'(1);
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    // Ready is registered from the next count, so it is never optimistic.
    s_nxt.rdy = (s_nxt.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_r <= '0;
      s_r.rdy <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[s_r.wp] <= i_in_data;
  end

  assign o_in_ready = s_r.rdy;
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data = mem[s_r.rp];

endmodule // lcd_pix_fifo

// [lcd_panel_timing_gen.sv]
// Passive LCD panel timing generator: shift clock, line clock, frame
// signal and panel data paced from a pixel prescale tick.
// Assumes the configuration inputs come from core-clock logic and are
// held steady while I_ENABLE is high.
`timescale 1ns/1ps
module lcd_panel_timing_gen
  import lcd_timing_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_ENABLE,
  input wire logic [2:0] I_PRESCALE_SELECT,
  input wire logic [4:0] I_SHIFT_PERIOD_COUNT,
  input wire logic [4:0] I_SHIFT_HIGH_COUNT,
  input wire logic [4:0] I_LINE_RISE_OFFSET,
  input wire logic [4:0] I_LINE_FALL_OFFSET,
  input wire logic [7:0] I_LINE_WIDTH_COUNT,
  input wire logic [7:0] I_PANEL_HEIGHT_COUNT,
  input wire logic [1:0] I_BUS_WIDTH,
  input wire logic I_PIX_VALID,
  input wire logic [PIX_W-1:0] I_PIX_DATA,
  output logic O_PIX_READY,
  output logic O_SHIFT_CLOCK,
  output logic O_LINE_CLOCK,
  output logic O_FRAME,
  output logic [PIX_W-1:0] O_PANEL_DATA,
  output logic O_UNDERRUN,
  output logic O_ACTIVE
);

  // ****************************************************************
  // Configuration bundle and derived lengths
  // ****************************************************************
  cfg_t cfg;
  tim_st_t s_r;
  tim_st_t s_nxt;
  logic tick;
  logic start;
  logic line_start;
  logic pop;
  logic fifo_valid;
  logic [PIX_W-1:0] fifo_data;
  logic [10:0] line_len;
  logic [9:0] rows;
  logic [8:0] last_row;
  logic [5:0] rise_at;
  logic [5:0] fall_at;

  assign cfg = '{prescale_select: I_PRESCALE_SELECT,
    shift_period_count: I_SHIFT_PERIOD_COUNT,
    shift_high_count: I_SHIFT_HIGH_COUNT,
    line_rise_offset: I_LINE_RISE_OFFSET,
    line_fall_offset: I_LINE_FALL_OFFSET,
    line_width_count: I_LINE_WIDTH_COUNT,
    panel_height_count: I_PANEL_HEIGHT_COUNT,
    bus_width: I_BUS_WIDTH};

  // Shift clocks per line: (width + 1) scaled by the bus factor.
  always_comb
  begin
    line_len = {3'h0, cfg.line_width_count} + 11'h001;
    case (cfg.bus_width)
      BUS_1BIT: line_len = line_len << 2;
      BUS_2BIT: line_len = line_len << 1;
      default: line_len = line_len;
    endcase
  end

  // Two line clocks per panel row pair, as for a split-scan panel.
  // A full-height panel has 512 rows, one bit more than the row counter
  // needs, so the last row is formed directly as 2H+1.
  assign rows = ({2'h0, cfg.panel_height_count} + 10'h001) << 1;
  assign last_row = {cfg.panel_height_count, 1'b1};
  assign rise_at = {1'b0, cfg.line_rise_offset} + 6'h01;
  assign fall_at = {1'b0, cfg.line_fall_offset} + 6'h01;

  // ****************************************************************
  // Prescale tick and pixel FIFO
  // ****************************************************************
  lcd_prescaler u_pre (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_run(s_r.mode == ST_RUN),
    .i_sel(cfg.prescale_select),
    .o_tick(tick)
  );

  lcd_pix_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_in_valid(I_PIX_VALID),
    .i_in_data(I_PIX_DATA),
    .o_in_ready(O_PIX_READY),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(pop)
  );

  // Keeps only the lanes the panel bus really has.
  function automatic logic [PIX_W-1:0] lane_mask(
    input logic [1:0] bw,
    input logic [PIX_W-1:0] d
  );
    case (bw)
      BUS_1BIT: lane_mask = {3'h0, d[0]};
      BUS_2BIT: lane_mask = {2'h0, d[1:0]};
      default: lane_mask = d;
    endcase
  endfunction

  // ****************************************************************
  // Timing state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    start = 1'b0;
    line_start = 1'b0;
    pop = 1'b0;
    case (s_r.mode)
      ST_IDLE:
      begin
        if (I_ENABLE)
        begin
          // Park the shift, index and row counters on their last step so the first tick opens
          // shift 0 of line 0 of a fresh frame.
          s_nxt.mode = ST_RUN;
          s_nxt.sph = cfg.shift_period_count;
          s_nxt.idx = line_len - 11'h001;
          s_nxt.row = last_row;
        end
      end
      ST_RUN:
      begin
        if (!I_ENABLE)
        begin
          s_nxt = TIM_RST;
        end
        else if (tick)
        begin
          start = (s_r.sph >= cfg.shift_period_count);
          s_nxt.sph = start ? 5'h00 : s_r.sph + 5'h01;
          s_nxt.shift_clock = (s_nxt.sph <= cfg.shift_high_count);
          if (start)
          begin
            line_start = (s_r.idx >= line_len - 11'h001);
            s_nxt.idx = line_start ? 11'h000 : s_r.idx + 11'h001;
            // Data moves on the rising edge and is sampled on the fall.
            pop = 1'b1;
            s_nxt.data = fifo_valid ?
              lane_mask(cfg.bus_width, fifo_data) : DATA_RST;
            s_nxt.underrun = s_r.underrun | !fifo_valid;
            if (s_r.fdly != 2'h0)
            begin
              s_nxt.fdly = s_r.fdly - 2'h1;
              if (s_r.fdly == 2'h1)
              begin
                if (s_r.frow == last_row)
                  s_nxt.frame = 1'b1;
                else if (s_r.frow == 9'h000)
                  s_nxt.frame = 1'b0;
              end
            end
          end
          if (line_start)
          begin
            s_nxt.row = (s_r.row >= last_row) ? 9'h000 :
              s_r.row + 9'h001;
            // The offset count is zero on the line's first shift rise, so
            // an offset of N lands a full N+1 ticks after that rise.
            s_nxt.lofs = 6'h00;
          end
          else if (s_r.lofs != LOFS_IDLE)
          begin
            s_nxt.lofs = s_r.lofs + 6'h01;
          end
          if (s_nxt.lofs == rise_at)
          begin
            s_nxt.lclk = 1'b1;
            s_nxt.frow = s_nxt.row;
            s_nxt.fdly = FRAME_EDGE_SHIFTS;
          end
          // With equal offsets the fall wins and no pulse appears.
          if (s_nxt.lofs == fall_at)
            s_nxt.lclk = 1'b0;
        end
      end
      default:
      begin
        s_nxt = TIM_RST;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      s_r <= TIM_RST;
    else
      s_r <= s_nxt;
  end

  assign O_SHIFT_CLOCK = s_r.shift_clock;
  assign O_LINE_CLOCK = s_r.lclk;
  assign O_FRAME = s_r.frame;
  assign O_PANEL_DATA = s_r.data;
  assign O_UNDERRUN = s_r.underrun;
  assign O_ACTIVE = (s_r.mode == ST_RUN);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  logic run;
  assign run = (s_r.mode == ST_RUN) && I_ENABLE;

  shift_rise_a: assert property (
    (run && tick && s_r.sph == cfg.shift_period_count)
    |=> (O_SHIFT_CLOCK && s_r.sph == 5'h00))
    else $error("Shift clock did not rise at period end.");

  shift_low_a: assert property (
    (run && tick && s_r.sph < cfg.shift_period_count
     && s_r.sph >= cfg.shift_high_count)
    |=> !O_SHIFT_CLOCK)
    else $error("Shift clock high beyond its high count.");

  line_rise_a: assert property (
    (O_ACTIVE && $rose(O_LINE_CLOCK)) |-> (s_r.lofs == rise_at))
    else $error("Line clock rose at the wrong offset.");

  line_fall_a: assert property (
    (O_ACTIVE && $fell(O_LINE_CLOCK)) |-> (s_r.lofs == fall_at))
    else $error("Line clock fell at the wrong offset.");

  line_wrap_a: assert property (
    (run && tick && s_r.sph == cfg.shift_period_count
     && s_r.idx == line_len - 11'h001)
    |=> (s_r.idx == 11'h000 && s_r.lofs == 6'h00))
    else $error("Line did not wrap after its shift count.");

  bus_factor_a: assert property (
    O_ACTIVE |-> (s_r.idx < line_len
      && (cfg.bus_width != BUS_1BIT || O_PANEL_DATA[3:1] == 3'h0)))
    else $error("Line index or lanes exceed the bus factor.");

  frame_on_a: assert property (
    (O_ACTIVE && $rose(O_FRAME)) |-> (s_r.frow == last_row
      && s_r.fdly == 2'h0 && $past(s_r.fdly) == 2'h1))
    else $error("Frame rose off the last line.");

  frame_off_a: assert property (
    (O_ACTIVE && $fell(O_FRAME)) |-> (s_r.frow == 9'h000
      && $past(s_r.fdly) == 2'h1))
    else $error("Frame fell off the first line.");

  row_range_a: assert property (
    (O_ACTIVE && s_r.idx != line_len - 11'h001) |-> (s_r.row < rows))
    else $error("Row counter passed the frame length.");

  data_hold_a: assert property (
    (run && !(tick && s_r.sph >= cfg.shift_period_count))
    |=> $stable(O_PANEL_DATA))
    else $error("Panel data moved away from a shift rise.");

  underrun_data_a: assert property (
    (run && tick && s_r.sph >= cfg.shift_period_count && !fifo_valid)
    |=> (O_UNDERRUN && O_PANEL_DATA == DATA_RST))
    else $error("Dry buffer did not give blank data and a flag.");

  lane_two_a: assert property (
    (O_ACTIVE && cfg.bus_width == BUS_2BIT) |-> (O_PANEL_DATA[3:2] == 2'h0))
    else $error("Unused lanes of a two-bit bus were driven.");

  frame_step_a: assert property (
    (run && !(tick && s_r.sph >= cfg.shift_period_count))
    |=> $stable(O_FRAME))
    else $error("Frame moved away from a shift rise.");

  frame_rise_c: cover property (O_ACTIVE && $rose(O_FRAME));
  frame_fall_c: cover property (O_ACTIVE && $fell(O_FRAME));
  line_pulse_c: cover property ($rose(O_LINE_CLOCK) ##[1:200]
    $fell(O_LINE_CLOCK));
  underrun_c: cover property ($rose(O_UNDERRUN));
  two_bit_c: cover property (O_ACTIVE && cfg.bus_width == BUS_2BIT
    && O_SHIFT_CLOCK);

endmodule // lcd_panel_timing_gen

// [lcd_panel_model.sv]
// Passive panel model: times the strobes and samples panel data.
// Assumes it shares the core clock with the timing generator.
`timescale 1ns/1ps
module lcd_panel_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sh,
  input wire logic i_ln,
  input wire logic i_fr,
  input wire logic [3:0] i_d,
  output int o_m[9],
  output int o_bad,
  output logic o_smp,
  output logic [3:0] o_sd
);
  int t, tsh, tln, tfr, cnt;
  logic psh, pln, pfr;
  logic [3:0] pd;

  // ****************************************************************
  // Edge timing, in core cycles or shift counts
  // ****************************************************************
  // Slot 0 shift period, 1 shift high, 2 line offset, 3 line high,
  // 4 line period, 5 and 6 shifts before frame rise and fall,
  // 7 frame period, 8 frame high. The first value of slots 0, 4 and 7 is stale.
  always @(posedge i_clk)
  begin
    o_smp <= 1'b0;
    t++;
    if (i_rst)
    begin
      foreach (o_m[k])
        o_m[k] = -1;
      o_bad = 0;
      {psh, pln, pfr, pd} = 7'h00;
    end
    else
    begin
      if (i_sh && !psh)
      begin
        o_m[0] = t - tsh;
        tsh = t;
        cnt++;
      end
      if (!i_sh && psh)
      begin
        o_m[1] = t - tsh;
        o_smp <= 1'b1;
        o_sd <= i_d;
      end
      // The panel latches on the falling edge, so data may move only
      // where the shift clock rises.
      if (i_d !== pd && !(i_sh && !psh))
        o_bad++;
      if (i_ln && !pln)
      begin
        o_m[2] = t - tsh;
        o_m[4] = t - tln;
        tln = t;
        cnt = 0;
      end
      if (!i_ln && pln)
        o_m[3] = t - tln;
      if (i_fr && !pfr)
      begin
        o_m[5] = cnt;
        o_m[7] = t - tfr;
        tfr = t;
      end
      if (!i_fr && pfr)
      begin
        o_m[6] = cnt;
        o_m[8] = t - tfr;
      end
      {psh, pln, pfr, pd} = {i_sh, i_ln, i_fr, i_d};
    end
  end
endmodule // lcd_panel_model

// [lcd_panel_timing_gen_tb.sv]
// Self-checking bench of the panel timing generator with random setups.
// Assumes the panel model file and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  errors++; $display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
module lcd_panel_timing_gen_tb
  import lcd_timing_pkg::*;
();
  logic I_CORE_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_ENABLE = 1'b0;
  logic I_PIX_VALID = 1'b0;
  logic [PIX_W-1:0] I_PIX_DATA = '0;
  logic O_PIX_READY, O_SHIFT_CLOCK, O_LINE_CLOCK, O_FRAME;
  logic O_UNDERRUN, O_ACTIVE, smp, feed = 1'b0, tk;
  logic [PIX_W-1:0] O_PANEL_DATA, sd;
  logic [3:0] q[$];
  cfg_t c = '0;
  int errors, n_compared, cyc, m[9], bad, k, i, p, sc, lp, fp, sp, ro;

  // ****************************************************************
  // Clock, instances and pixel source
  // ****************************************************************
  always #(CLK_PERIOD_NS / 2) I_CORE_CLK = ~I_CORE_CLK;

  lcd_panel_timing_gen #(.FIFO_D(FIFO_DEPTH)) lcd_panel_timing_gen_i (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ENABLE(I_ENABLE),
    .I_PRESCALE_SELECT(c.prescale_select),
    .I_SHIFT_PERIOD_COUNT(c.shift_period_count),
    .I_SHIFT_HIGH_COUNT(c.shift_high_count),
    .I_LINE_RISE_OFFSET(c.line_rise_offset),
    .I_LINE_FALL_OFFSET(c.line_fall_offset),
    .I_LINE_WIDTH_COUNT(c.line_width_count),
    .I_PANEL_HEIGHT_COUNT(c.panel_height_count),
    .I_BUS_WIDTH(c.bus_width), .I_PIX_VALID(I_PIX_VALID),
    .I_PIX_DATA(I_PIX_DATA), .O_PIX_READY(O_PIX_READY),
    .O_SHIFT_CLOCK(O_SHIFT_CLOCK), .O_LINE_CLOCK(O_LINE_CLOCK),
    .O_FRAME(O_FRAME), .O_PANEL_DATA(O_PANEL_DATA),
    .O_UNDERRUN(O_UNDERRUN), .O_ACTIVE(O_ACTIVE));

  lcd_panel_model lcd_panel_model_i (.i_clk(I_CORE_CLK),
    .i_rst(I_RST || !I_ENABLE), .i_sh(O_SHIFT_CLOCK),
    .i_ln(O_LINE_CLOCK), .i_fr(O_FRAME), .i_d(O_PANEL_DATA),
    .o_m(m), .o_bad(bad), .o_smp(smp), .o_sd(sd));

  function automatic int wf(logic [1:0] b);
    return b == BUS_1BIT ? 4 : b == BUS_2BIT ? 2 : 1;
  endfunction

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // An empty queue means the source has run dry: lanes must read zero.
  task automatic chk_pix();
    logic [3:0] e;
    e = q.size() ? q.pop_front() : DATA_RST;
    if (c.bus_width == BUS_1BIT)
      e &= 4'h1;
    else if (c.bus_width == BUS_2BIT)
      e &= 4'h3;
    `CHK("panel data", e, sd)
  endtask

  // A refused word keeps its value until it is taken.
  always @(posedge I_CORE_CLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      final_report();
    end
    else
    begin
      if (smp)
        chk_pix();
      tk = I_PIX_VALID && O_PIX_READY;
      if (tk)
        q.push_back(I_PIX_DATA);
      #1;
      if (tk || !I_PIX_VALID)
        I_PIX_DATA = PIX_W'($urandom);
      I_PIX_VALID = feed || (I_PIX_VALID && !tk);
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  task automatic rand_cfg(int k);
    sp = 1 + $urandom % 5;
    ro = $urandom % sp;
    c.prescale_select = 3'($urandom % 3);
    c.shift_period_count = 5'(sp);
    c.shift_high_count = 5'($urandom % sp);
    c.line_rise_offset = 5'(ro);
    c.line_fall_offset = 5'(ro + 1 + $urandom % (sp - ro));
    c.line_width_count = 8'(1 + $urandom % 3);
    c.panel_height_count = 8'($urandom % 3);
    c.bus_width = 2'(k);
    if (k == 0)
      c = '{shift_period_count: 5'h01, line_fall_offset: 5'h01,
        default: '0};
  endtask

  initial
  begin
    void'($urandom(87));
    repeat (3) @(posedge I_CORE_CLK);
    #1;
    I_RST = 1'b0;
    `CHK("reset outs", 10'h001, {O_SHIFT_CLOCK, O_LINE_CLOCK, O_FRAME,
      O_UNDERRUN, O_ACTIVE, O_PANEL_DATA, O_PIX_READY})
    // The slowest setup keeps the buffer unread while it is filled.
    c = '{prescale_select: 3'h7, shift_period_count: 5'h1F, default: '0};
    I_ENABLE = 1'b1;
    @(posedge I_CORE_CLK);
    feed = 1'b1;
    #1;
    `CHK("active", 1'b1, O_ACTIVE)
    repeat (24) @(posedge I_CORE_CLK);
    feed = 1'b0;
    #1;
    `CHK("accepted", FIFO_DEPTH, q.size())
    `CHK("full ready", 1'b0, O_PIX_READY)
    I_RST = 1'b1;
    I_ENABLE = 1'b0;
    repeat (2) @(posedge I_CORE_CLK);
    #1;
    I_RST = 1'b0;
    q.delete();
    `CHK("ready", 1'b1, O_PIX_READY)
    $display("test fill done");
    for (k = 0; k < 4; k++)
    begin
      @(posedge I_CORE_CLK);
      feed = 1'b1;
      #1;
      rand_cfg(k);
      I_ENABLE = 1'b1;
      p = 1 << c.prescale_select;
      sc = (c.shift_period_count + 1) * p;
      lp = sc * (c.line_width_count + 1) * wf(c.bus_width);
      fp = 2 * lp * (c.panel_height_count + 1);
      repeat (2 * fp + 3 * lp + 50) @(posedge I_CORE_CLK);
      #1;
      `CHK("shift period", sc, m[0])
      `CHK("shift high", (c.shift_high_count + 1) * p, m[1])
      `CHK("line offset", (c.line_rise_offset + 1) * p, m[2])
      sp = c.line_fall_offset - c.line_rise_offset;
      `CHK("line high", sp * p, m[3])
      `CHK("line period", lp, m[4])
      `CHK("frame rise", 2, m[5])
      `CHK("frame fall", 2, m[6])
      `CHK("frame high", lp, m[8])
      `CHK("frame period", fp, m[7])
      `CHK("data moves", 0, bad)
      `CHK("underrun", 1'b0, O_UNDERRUN)
      @(posedge I_CORE_CLK);
      feed = 1'b0;
      for (i = 0; i < 2000 && O_UNDERRUN !== 1'b1; i++)
        @(posedge I_CORE_CLK);
      repeat (2 * sc) @(posedge I_CORE_CLK);
      #1;
      `CHK("underrun", 1'b1, O_UNDERRUN)
      I_ENABLE = 1'b0;
      @(posedge I_CORE_CLK);
      #1;
      `CHK("stop", 2'h0, {O_ACTIVE, O_UNDERRUN})
      q.delete();
      $display("test setup %0d done", k);
    end
    final_report();
  end
endmodule // lcd_panel_timing_gen_tb
